// ### adc_ctl.sv
// Register and result-handling logic of the converter control block.
// Assumes the analog core pulses conv_done with conv_data on sys_clk; clocks arrive as levels.
// What this block does
// RL1 - Compare runs only while compare enable is set.
// RL2 - Polarity clear: true if result below value; set: true if greater or equal.
// RL3 - Result high holds the top two bits of a 10-bit result.
// RL4 - In 8-bit mode the result high bits read zero.
// RL5 - Results load on every completion unless compare enabled and false.
// RL6 - In 10-bit mode reading result high locks results until result low read.
// RL7 - A completion while locked is discarded, never held.
// RL8 - In 8-bit mode there is no read interlock.
// RL9 - Software treats results invalid after a mode change until next completion.
// RL10 - Result low holds the low eight bits, or whole 8-bit result.
// RL11 - Compare high bits are used only in 10-bit mode.
// RL12 - Compare low bits are used in both modes.
// RL13 - Configuration bit 7 selects low power when set.
// RL14 - Divider field divides selected clock by 1, 2, 4 or 8; converter_clock is the source divided by 2, 4, 8 or 16.
// RL15 - Configuration bit 4 selects long sample when set.
// RL16 - Mode 00 gives 8-bit, 10 gives 10-bit; others reserved.
// RL17 - Clock source: bus, bus halved, alternate, internal asynchronous.
// RL18 - Each pin release bit removes digital control from that channel pin.
// RL19 - Complete flag sets on every completion, or only true compares when enabled.
// RL20 - Complete flag clears on status one write or result low read.
// RL21 - Interlock releases at reset and whenever the mode changes.
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
module adc_ctl (
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic        clk_en,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        conv_done,
   input  wire logic [9:0]  conv_data,
   input  wire logic        conv_active,
   input  wire logic        alternate_clock,
   input  wire logic        internal_async_clock,
   output logic             converter_clock,
   output logic             low_power_select,
   output logic             long_sample_select,
   output logic             ten_bit_mode,
   output logic [7:0]       pin_digital_release,
   output logic             conversion_complete_flag
);

   adc_ctl_pkg::cfg_t cfg_q;
   logic [7:0]  sc2_q;
   logic [7:0]  cvh_q;
   logic [7:0]  cvl_q;
   logic [7:0]  pc1_q;
   logic [9:0]  res_q;
   logic        lock_q;
   logic        conversion_complete_flag_q;
   logic [2:0]  div_cnt_q;
   logic        half_q;
   logic        ck_q;
   logic [1:0]  alt_sync_q;
   logic [1:0]  asy_sync_q;

   logic        wr;
   logic        rd;
   logic        mapped;
   logic        mode10;
   logic [9:0]  cmp_res;
   logic [9:0]  cmp_val;
   logic        cmp_true;
   logic        accept;
   logic        load_ok;
   logic        src_clk;
   logic        mode_wr_change;

   assign pready  = 1'b1;
   assign mapped  = (paddr == adc_ctl_pkg::OFF_SC1) || (paddr == adc_ctl_pkg::OFF_SC2) ||
                    (paddr == adc_ctl_pkg::OFF_RH)  || (paddr == adc_ctl_pkg::OFF_RL)  ||
                    (paddr == adc_ctl_pkg::OFF_CVH) || (paddr == adc_ctl_pkg::OFF_CVL) ||
                    (paddr == adc_ctl_pkg::OFF_CFG) || (paddr == adc_ctl_pkg::OFF_PC1);
   assign pslverr = psel && penable && !mapped;
   // Accesses are only taken while the clock enable is high, so frozen state stays frozen.
   assign wr = psel && penable && pwrite && mapped && clk_en;
   assign rd = psel && penable && !pwrite && mapped && clk_en;

   assign mode10 = (cfg_q.mode == adc_ctl_pkg::MODE_10); // [RL16]

   // In 8-bit mode the upper bits of both operands are forced equal so only the low byte counts.
   always_comb begin
      cmp_res = mode10 ? conv_data : {2'h0, conv_data[7:0]}; // [RL11] [RL12]
      cmp_val = mode10 ? {cvh_q[1:0], cvl_q} : {2'h0, cvl_q}; // [RL11] [RL12]
      cmp_true = sc2_q[adc_ctl_pkg::SC2_CMPG_POS] ? (cmp_res >= cmp_val)
                                                  : (cmp_res < cmp_val); // [RL2]
   end

   assign accept  = !sc2_q[adc_ctl_pkg::SC2_CMPE_POS] || cmp_true; // [RL1] [RL5]
   assign load_ok = conv_done && accept && !(mode10 && lock_q); // [RL6] [RL7] [RL8]
   assign mode_wr_change = wr && (paddr == adc_ctl_pkg::OFF_CFG) &&
                           (pwdata[3:2] != cfg_q.mode);

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_q <= adc_ctl_pkg::cfg_t'(adc_ctl_pkg::CFG_RESET);
         sc2_q <= adc_ctl_pkg::SC2_RESET;
         cvh_q <= adc_ctl_pkg::CV_RESET;
         cvl_q <= adc_ctl_pkg::CV_RESET;
         pc1_q <= adc_ctl_pkg::PC1_RESET;
      end else if (wr) begin
         case (paddr)
            adc_ctl_pkg::OFF_SC2: sc2_q <= {2'h0, pwdata[5:4], 4'h0};
            adc_ctl_pkg::OFF_CVH: cvh_q <= {6'h00, pwdata[1:0]};
            adc_ctl_pkg::OFF_CVL: cvl_q <= pwdata[7:0];
            adc_ctl_pkg::OFF_CFG: cfg_q <= adc_ctl_pkg::cfg_t'(pwdata[7:0]); // [RL13] [RL15]
            adc_ctl_pkg::OFF_PC1: pc1_q <= pwdata[7:0]; // [RL18]
            default: ;
         endcase
      end
   end

   // Result storage; the high bits are loaded as zero in 8-bit mode.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         res_q <= 10'h000;
      end else if (clk_en && load_ok) begin
         res_q <= mode10 ? conv_data : {2'h0, conv_data[7:0]}; // [RL3] [RL4] [RL10]
      end
   end

   // Interlock: set by a high read in 10-bit mode, dropped by a low read or a mode change.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         lock_q <= 1'b0; // [RL21]
      end else if (clk_en) begin
         if (mode_wr_change || !mode10) begin
            lock_q <= 1'b0; // [RL21] [RL8]
         end else if (rd && paddr == adc_ctl_pkg::OFF_RL) begin
            lock_q <= 1'b0; // [RL6]
         end else if (rd && paddr == adc_ctl_pkg::OFF_RH) begin
            lock_q <= 1'b1; // [RL6]
         end
      end
   end

   // Completion wins over a clearing access in the same cycle.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         conversion_complete_flag_q <= 1'b0;
      end else if (clk_en) begin
         if (conv_done && accept) begin
            conversion_complete_flag_q <= 1'b1; // [RL19]
         end else if ((wr && paddr == adc_ctl_pkg::OFF_SC1) ||
                      (rd && paddr == adc_ctl_pkg::OFF_RL)) begin
            conversion_complete_flag_q <= 1'b0; // [RL20]
         end
      end
   end

   // External clock levels are synchronised before use.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         alt_sync_q <= 2'h0;
         asy_sync_q <= 2'h0;
      end else if (clk_en) begin
         alt_sync_q <= {alt_sync_q[0], alternate_clock};
         asy_sync_q <= {asy_sync_q[0], internal_async_clock};
      end
   end

   // The bus-clock source is modelled as a one-cycle tick; the divider counts source rises.
   logic alt_prev_q;
   logic asy_prev_q;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         half_q     <= 1'b0;
         alt_prev_q <= 1'b0;
         asy_prev_q <= 1'b0;
      end else if (clk_en) begin
         half_q     <= !half_q;
         alt_prev_q <= alt_sync_q[1];
         asy_prev_q <= asy_sync_q[1];
      end
   end

   always_comb begin
      case (cfg_q.clock_source_field) // [RL17]
         adc_ctl_pkg::SRC_BUS:     src_clk = 1'b1;
         adc_ctl_pkg::SRC_BUS_DIV: src_clk = half_q;
         adc_ctl_pkg::SRC_ALT:     src_clk = alt_sync_q[1] && !alt_prev_q;
         adc_ctl_pkg::SRC_ASYNC:   src_clk = asy_sync_q[1] && !asy_prev_q;
         default:                  src_clk = 1'b0;
      endcase
   end

   // Output toggles once per divided source tick, so converter_clock is tick-rate / (2*div).
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         div_cnt_q <= 3'h0;
         ck_q      <= 1'b0;
      end else if (clk_en && src_clk) begin
         if (div_cnt_q >= ((3'h1 << cfg_q.clock_divide_field) - 3'h1)) begin // [RL14]
            div_cnt_q <= 3'h0;
            ck_q      <= !ck_q;
         end else begin
            div_cnt_q <= div_cnt_q + 3'h1;
         end
      end
   end

   always_comb begin
      prdata = 32'h0000_0000;
      case (paddr)
         adc_ctl_pkg::OFF_SC1: prdata[adc_ctl_pkg::SC1_CONVERSION_COMPLETE_FLAG_POS] = conversion_complete_flag_q;
         adc_ctl_pkg::OFF_SC2: prdata[7:0] = {conv_active, 1'b0, sc2_q[5:4], 4'h0};
         adc_ctl_pkg::OFF_RH:  prdata[1:0] = res_q[9:8]; // [RL3] [RL4]
         adc_ctl_pkg::OFF_RL:  prdata[7:0] = res_q[7:0]; // [RL10]
         adc_ctl_pkg::OFF_CVH: prdata[7:0] = cvh_q;
         adc_ctl_pkg::OFF_CVL: prdata[7:0] = cvl_q;
         adc_ctl_pkg::OFF_CFG: prdata[7:0] = cfg_q;
         adc_ctl_pkg::OFF_PC1: prdata[7:0] = pc1_q;
         default: prdata = 32'h0000_0000;
      endcase
   end

   assign converter_clock          = ck_q;
   assign low_power_select         = cfg_q.low_power_select; // [RL13]
   assign long_sample_select       = cfg_q.long_sample_select; // [RL15]
   assign ten_bit_mode             = mode10;
   assign pin_digital_release      = pc1_q; // [RL18]
   assign conversion_complete_flag = conversion_complete_flag_q;

   // RL9 binds software: results are simply whatever was last loaded after a mode change.

   property p_locked_hold;
      @(posedge sys_clk) disable iff (!rst_n)
      (clk_en && mode10 && lock_q && conv_done && !mode_wr_change) |=> $stable(res_q);
   endproperty
   a_locked_hold: assert property (p_locked_hold) else $error("result changed while locked"); // [RL7]

   property p_lock_set;
      @(posedge sys_clk) disable iff (!rst_n)
      (clk_en && rd && paddr == adc_ctl_pkg::OFF_RH && mode10 && !mode_wr_change) |=> lock_q;
   endproperty
   a_lock_set: assert property (p_lock_set) else $error("high read did not lock"); // [RL6]

   property p_no_lock_8;
      @(posedge sys_clk) disable iff (!rst_n) (clk_en && !mode10) |=> !lock_q;
   endproperty
   a_no_lock_8: assert property (p_no_lock_8) else $error("lock in 8-bit mode"); // [RL8]

   property p_rh_zero_8;
      @(posedge sys_clk) disable iff (!rst_n)
      (clk_en && load_ok && !mode10) |=> res_q[9:8] == 2'h0;
   endproperty
   a_rh_zero_8: assert property (p_rh_zero_8) else $error("upper bits nonzero in 8-bit"); // [RL4]

   property p_load;
      @(posedge sys_clk) disable iff (!rst_n)
      (clk_en && conv_done && mode10 && !lock_q && !sc2_q[adc_ctl_pkg::SC2_CMPE_POS])
      |=> res_q == $past(conv_data);
   endproperty
   a_load: assert property (p_load) else $error("result not loaded"); // [RL5] [RL3]

   property p_cmp_false_hold;
      @(posedge sys_clk) disable iff (!rst_n)
      (clk_en && conv_done && sc2_q[adc_ctl_pkg::SC2_CMPE_POS] && !cmp_true)
      |=> $stable(res_q) && !$rose(conversion_complete_flag_q);
   endproperty
   a_cmp_false_hold: assert property (p_cmp_false_hold) else $error("false compare loaded"); // [RL1]

   property p_conversion_complete_flag_set;
      @(posedge sys_clk) disable iff (!rst_n) (clk_en && conv_done && accept) |=> conversion_complete_flag_q;
   endproperty
   a_conversion_complete_flag_set: assert property (p_conversion_complete_flag_set) else $error("complete flag not set"); // [RL19]

   property p_conversion_complete_flag_clr;
      @(posedge sys_clk) disable iff (!rst_n)
      (clk_en && rd && paddr == adc_ctl_pkg::OFF_RL && !conv_done) |=> !conversion_complete_flag_q;
   endproperty
   a_conversion_complete_flag_clr: assert property (p_conversion_complete_flag_clr) else $error("complete flag not cleared"); // [RL20]

   // Helper for the divider checks: the last count before the output toggles.
   logic [2:0] div_last;
   assign div_last = (3'h1 << cfg_q.clock_divide_field) - 3'h1;

   // The interlock is a two-step exchange, so its steps are named once; only the high-read step is reused, by two checks.
   sequence s_high_read;
      clk_en && rd && paddr == adc_ctl_pkg::OFF_RH && mode10 && !mode_wr_change;
   endsequence

   sequence s_low_read;
      clk_en && rd && paddr == adc_ctl_pkg::OFF_RL;
   endsequence

   sequence s_locked_done;
      clk_en && conv_done && mode10 && lock_q && !mode_wr_change;
   endsequence

   property p_high_then_low;
      @(posedge sys_clk) disable iff (!rst_n)
      s_high_read ##1 s_low_read |=> !lock_q;
   endproperty
   a_high_then_low: assert property (p_high_then_low) else $error("low read kept lock"); // [RL6]

   property p_lock_drops_result;
      @(posedge sys_clk) disable iff (!rst_n)
      s_high_read ##1 s_locked_done |=> $stable(res_q);
   endproperty
   a_lock_drops_result: assert property (p_lock_drops_result) else $error("locked load"); // [RL7]

   property p_mode_unlock;
      @(posedge sys_clk) disable iff (!rst_n) (clk_en && mode_wr_change) |=> !lock_q;
   endproperty
   a_mode_unlock: assert property (p_mode_unlock) else $error("mode change kept lock"); // [RL21]

   property p_sc1_clear;
      @(posedge sys_clk) disable iff (!rst_n)
      (clk_en && wr && paddr == adc_ctl_pkg::OFF_SC1 && !conv_done) |=> !conversion_complete_flag_q;
   endproperty
   a_sc1_clear: assert property (p_sc1_clear) else $error("status write kept flag"); // [RL20]

   // A locked completion is dropped, yet an accepted one still raises the flag.
   property p_locked_flag;
      @(posedge sys_clk) disable iff (!rst_n)
      (clk_en && conv_done && accept && mode10 && lock_q) |=> conversion_complete_flag_q;
   endproperty
   a_locked_flag: assert property (p_locked_flag) else $error("locked completion no flag"); // [RL19]

   property p_load_8;
      @(posedge sys_clk) disable iff (!rst_n)
      (clk_en && conv_done && accept && !mode10)
      |=> res_q == {2'h0, $past(conv_data[7:0])};
   endproperty
   a_load_8: assert property (p_load_8) else $error("8-bit result not loaded"); // [RL8] [RL10]

   property p_freeze;
      @(posedge sys_clk) disable iff (!rst_n)
      !clk_en |=> $stable(cfg_q) && $stable(res_q) && $stable(lock_q) && $stable(conversion_complete_flag_q) &&
                  $stable(pc1_q) && $stable(sc2_q) && $stable(ck_q);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while frozen");

   property p_pin_write;
      @(posedge sys_clk) disable iff (!rst_n)
      (wr && paddr == adc_ctl_pkg::OFF_PC1) |=> pin_digital_release == $past(pwdata[7:0]);
   endproperty
   a_pin_write: assert property (p_pin_write) else $error("pin release not written"); // [RL18]

   property p_cfg_levels;
      @(posedge sys_clk) disable iff (!rst_n)
      (wr && paddr == adc_ctl_pkg::OFF_CFG)
      |=> low_power_select == $past(pwdata[7]) && long_sample_select == $past(pwdata[4]);
   endproperty
   a_cfg_levels: assert property (p_cfg_levels) else $error("config level wrong"); // [RL13] [RL15]

   property p_mode_decode;
      @(posedge sys_clk) disable iff (!rst_n)
      (wr && paddr == adc_ctl_pkg::OFF_CFG)
      |=> ten_bit_mode == ($past(pwdata[3:2]) == adc_ctl_pkg::MODE_10);
   endproperty
   a_mode_decode: assert property (p_mode_decode) else $error("mode decode wrong"); // [RL16]

   // Reserved codes must not count as 10-bit, or the interlock would engage by accident.
   property p_reserved_8;
      @(posedge sys_clk) disable iff (!rst_n)
      (cfg_q.mode != adc_ctl_pkg::MODE_10) |-> !ten_bit_mode;
   endproperty
   a_reserved_8: assert property (p_reserved_8) else $error("reserved mode as 10-bit"); // [RL16]

   property p_div_toggle;
      @(posedge sys_clk) disable iff (!rst_n)
      (clk_en && src_clk && div_cnt_q >= div_last) |=> ck_q != $past(ck_q);
   endproperty
   a_div_toggle: assert property (p_div_toggle) else $error("divider did not toggle"); // [RL14]

   property p_div_hold;
      @(posedge sys_clk) disable iff (!rst_n)
      (clk_en && src_clk && div_cnt_q < div_last) |=> $stable(ck_q);
   endproperty
   a_div_hold: assert property (p_div_hold) else $error("divider toggled early"); // [RL14]

   property p_bus_tick;
      @(posedge sys_clk) disable iff (!rst_n)
      (cfg_q.clock_source_field == adc_ctl_pkg::SRC_BUS) |-> src_clk;
   endproperty
   a_bus_tick: assert property (p_bus_tick) else $error("bus source not ticking"); // [RL17]

   property p_compare_write;
      @(posedge sys_clk) disable iff (!rst_n)
      (wr && paddr == adc_ctl_pkg::OFF_SC2)
      |=> sc2_q[adc_ctl_pkg::SC2_CMPE_POS] == $past(pwdata[5]) &&
          sc2_q[adc_ctl_pkg::SC2_CMPG_POS] == $past(pwdata[4]);
   endproperty
   a_compare_write: assert property (p_compare_write) else $error("compare bits wrong"); // [RL1] [RL2]

endmodule

// ### adc_ctl_pkg.sv
// Package for the converter control block: register offsets, field positions, reset values.
// Assumes a 32-bit APB slave with one aligned word per register.
package adc_ctl_pkg;

   localparam logic [7:0] OFF_SC1 = 8'h00;
   localparam logic [7:0] OFF_SC2 = 8'h04;
   localparam logic [7:0] OFF_RH  = 8'h08;
   localparam logic [7:0] OFF_RL  = 8'h0C;
   localparam logic [7:0] OFF_CVH = 8'h10;
   localparam logic [7:0] OFF_CVL = 8'h14;
   localparam logic [7:0] OFF_CFG = 8'h18;
   localparam logic [7:0] OFF_PC1 = 8'h1C;

   localparam int SC1_CONVERSION_COMPLETE_FLAG_POS = 7;
   localparam int SC2_ACT_POS  = 7;
   localparam int SC2_CMPE_POS = 5;
   localparam int SC2_CMPG_POS = 4;
   localparam int CFG_LP_POS   = 7;
   localparam int CFG_DIV_LSB  = 5;
   localparam int CFG_LS_POS   = 4;
   localparam int CFG_MODE_LSB = 2;
   localparam int CFG_CLK_LSB  = 0;

   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [7:0] SC2_RESET = 8'h00;
   localparam logic [7:0] CV_RESET  = 8'h00;
   localparam logic [7:0] PC1_RESET = 8'h00;

   localparam logic [1:0] MODE_8  = 2'h0;
   localparam logic [1:0] MODE_10 = 2'h2;

   localparam logic [1:0] SRC_BUS     = 2'h0;
   localparam logic [1:0] SRC_BUS_DIV = 2'h1;
   localparam logic [1:0] SRC_ALT     = 2'h2;
   localparam logic [1:0] SRC_ASYNC   = 2'h3;

   typedef struct packed {
      logic       low_power_select;
      logic [1:0] clock_divide_field;
      logic       long_sample_select;
      logic [1:0] mode;
      logic [1:0] clock_source_field;
   } cfg_t;

   typedef struct packed {
      logic [9:0] value;
      logic       valid;
   } result_t;

endpackage

// ### tb.sv
// Self-checking testbench for the converter control block.
// Assumes adc_ctl and adc_ctl_pkg are compiled first; zero-wait APB slave.
module tb;
   timeunit 1ns;
   timeprecision 100ps;

   logic        sys_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        clk_en = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        conv_done = 1'b0;
   logic [9:0]  conv_data = 10'h000;
   logic        alt_clk = 1'b0;
   logic        async_clk = 1'b0;
   logic        conv_clk;
   logic        lp_out;
   logic        ls_out;
   logic        ten_out;
   logic [7:0]  pins;
   logic        flag;
   logic        act = 1'b0;
   logic [31:0] rdata;
   logic        rerr;
   logic [31:0] seed = 32'd74339;
   int          fails = 0;
   int          checks_done = 0;
   int          tick = 0;

   adc_ctl uut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .conv_done(conv_done), .conv_data(conv_data),
      .conv_active(act), .alternate_clock(alt_clk), .internal_async_clock(async_clk),
      .converter_clock(conv_clk), .low_power_select(lp_out), .long_sample_select(ls_out),
      .ten_bit_mode(ten_out), .pin_digital_release(pins), .conversion_complete_flag(flag));

   initial begin
      forever #2.5 sys_clk = ~sys_clk;
   end

   // Slow free-running sources with rising edges every 6 and 10 bus cycles.
   always @(posedge sys_clk) begin
      tick <= tick + 1;
      alt_clk <= (tick % 6) < 3;
      async_clk <= (tick % 10) < 5;
   end

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic bit hit(bit m10, bit ge, logic [9:0] cv, logic [9:0] r);
      logic [9:0] a;
      logic [9:0] b;
      a = m10 ? r : {2'b00, r[7:0]};
      b = m10 ? cv : {2'b00, cv[7:0]};
      return ge ? (a >= b) : (a < b);
   endfunction

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         fails++;
         $display("MISMATCH pready expected 1 seen timeout");
         wrap_up();
      end
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // One idle edge keeps the next call from raising psel in the step that lowered it.
      @(posedge sys_clk);
   endtask

   // Two edges: the pulse is taken at the first, its effects have landed by the second.
   task automatic conv(input logic [9:0] d);
      conv_done <= 1'b1;
      conv_data <= d;
      @(posedge sys_clk);
      conv_done <= 1'b0;
      conv_data <= ~d;
      @(posedge sys_clk);
   endtask

   task automatic rise(output int n);
      logic pv;
      n = 0;
      pv = conv_clk;
      do begin
         @(posedge sys_clk);
         n++;
         if (conv_clk === 1'b1 && pv === 1'b0) return;
         pv = conv_clk;
      end while (n < 400);
      fails++;
      $display("MISMATCH converter_clock expected edge seen timeout");
      wrap_up();
   endtask

   initial begin
      logic [31:0] r;
      logic [9:0]  cv;
      logic [9:0]  d;
      logic [9:0]  res_m;
      logic [7:0]  v;
      logic [7:0]  p;
      bit          m10;
      bit          ce;
      bit          ge;
      bit          upd;
      bit          valid_m;
      bit          last10;
      int          n;
      static logic [7:0] offs [6] = '{adc_ctl_pkg::OFF_SC1, adc_ctl_pkg::OFF_SC2,
         adc_ctl_pkg::OFF_CVH, adc_ctl_pkg::OFF_CVL, adc_ctl_pkg::OFF_CFG, adc_ctl_pkg::OFF_PC1};
      static int   base [4] = '{1, 2, 6, 10};
      valid_m = 0;
      last10 = 0;
      res_m = 10'h000;
      repeat (8) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      foreach (offs[i]) begin
         apb(1'b0, offs[i], 32'h0);
         chk("reset_value", 32'h0, rdata);
      end
      apb(1'b1, adc_ctl_pkg::OFF_RH, 32'hFF);
      apb(1'b0, adc_ctl_pkg::OFF_RH, 32'h0);
      chk("rh_read_only", 32'h0, rdata);
      apb(1'b0, 8'h20, 32'h0);
      chk("unmapped_err", 32'h1, {31'h0, rerr});
      act <= 1'b1;
      apb(1'b0, adc_ctl_pkg::OFF_SC2, 32'h0);
      chk("active_bit", 32'h80, rdata);
      act <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         r = xs();
         v = r[7:0] & 8'hFB;
         p = r[15:8];
         apb(1'b1, adc_ctl_pkg::OFF_CFG, {24'h0, v});
         apb(1'b1, adc_ctl_pkg::OFF_PC1, {24'h0, p});
         @(posedge sys_clk);
         apb(1'b0, adc_ctl_pkg::OFF_CFG, 32'h0);
         chk("cfg_readback", {24'h0, v}, rdata);
         chk("cfg_outputs", {29'h0, v[7], v[4], v[3:2] == 2'b10}, {29'h0, lp_out, ls_out, ten_out});
         chk("pin_release", {24'h0, p}, {24'h0, pins});
      end
      clk_en <= 1'b0;
      apb(1'b1, adc_ctl_pkg::OFF_PC1, {24'h0, ~p});
      clk_en <= 1'b1;
      apb(1'b0, adc_ctl_pkg::OFF_PC1, 32'h0);
      chk("pin_release_frozen", {24'h0, p}, rdata);
      for (int s = 0; s < 4; s++) begin
         for (int dv = 0; dv < 4; dv++) begin
            apb(1'b1, adc_ctl_pkg::OFF_CFG, {24'h0, 1'b0, dv[1:0], 3'b000, s[1:0]});
            rise(n);
            rise(n);
            rise(n);
            chk("clock_period", 2 * (1 << dv) * base[s], n);
         end
      end
      for (int i = 0; i < 40; i++) begin
         r = xs();
         m10 = r[0];
         ce = r[1];
         ge = r[2];
         cv = r[13:4];
         d = (i % 4 == 0) ? cv : r[25:16];
         apb(1'b1, adc_ctl_pkg::OFF_CFG, {28'h0, m10, 3'b000});
         // Results are not trusted after a resolution change until one loads.
         if (m10 != last10) valid_m = 0;
         last10 = m10;
         apb(1'b1, adc_ctl_pkg::OFF_SC2, {26'h0, ce, ge, 4'h0});
         apb(1'b1, adc_ctl_pkg::OFF_CVH, {30'h0, cv[9:8]});
         apb(1'b1, adc_ctl_pkg::OFF_CVL, {24'h0, cv[7:0]});
         apb(1'b1, adc_ctl_pkg::OFF_SC1, 32'h0);
         conv(d);
         upd = !ce || hit(m10, ge, cv, d);
         if (upd) res_m = d;
         if (upd) valid_m = 1;
         chk("flag_after_conv", {31'h0, upd}, {31'h0, flag});
         if (valid_m) begin
            apb(1'b0, adc_ctl_pkg::OFF_RH, 32'h0);
            chk("result_high", {30'h0, m10 ? res_m[9:8] : 2'b00}, rdata);
            apb(1'b0, adc_ctl_pkg::OFF_RL, 32'h0);
            chk("result_low", {24'h0, res_m[7:0]}, rdata);
         end
      end
      apb(1'b1, adc_ctl_pkg::OFF_CFG, 32'h08);
      apb(1'b1, adc_ctl_pkg::OFF_SC2, 32'h0);
      conv(10'h2A5);
      apb(1'b0, adc_ctl_pkg::OFF_RH, 32'h0);
      chk("locked_high", 32'h2, rdata);
      conv(10'h15A);
      apb(1'b0, adc_ctl_pkg::OFF_RL, 32'h0);
      chk("locked_low", 32'hA5, rdata);
      @(posedge sys_clk);
      chk("flag_low_read", 32'h0, {31'h0, flag});
      conv(10'h3C3);
      apb(1'b0, adc_ctl_pkg::OFF_RL, 32'h0);
      chk("after_unlock", 32'hC3, rdata);
      apb(1'b0, adc_ctl_pkg::OFF_RH, 32'h0);
      apb(1'b1, adc_ctl_pkg::OFF_CFG, 32'h00);
      conv(10'h1E7);
      apb(1'b0, adc_ctl_pkg::OFF_RL, 32'h0);
      chk("mode_change_unlock", 32'hE7, rdata);
      apb(1'b0, adc_ctl_pkg::OFF_RH, 32'h0);
      chk("eight_bit_high", 32'h0, rdata);
      conv(10'h0F0);
      apb(1'b0, adc_ctl_pkg::OFF_RL, 32'h0);
      chk("no_interlock", 32'hF0, rdata);
      conv(10'h011);
      chk("flag_set", 32'h1, {31'h0, flag});
      apb(1'b1, adc_ctl_pkg::OFF_SC1, 32'h0);
      @(posedge sys_clk);
      chk("flag_sc1_write", 32'h0, {31'h0, flag});
      wrap_up();
   end
endmodule
